// ==== verilog/silo_regs.svh ====
// Register offsets, field positions and timing figures of the receive silo block
`ifndef SILO_REGS_SVH
`define SILO_REGS_SVH
`define OFS_INT_CTRL 8'h00
`define OFS_LINE_EN 8'h04
`define OFS_SILO_WIN 8'h08
`define OFS_CAR_ASSERT 8'h0C
`define OFS_CAR_DETECT 8'h10
`define OFS_RING_DETECT 8'h14
`define OFS_SILO_PARAM 8'h18
`define OFS_PRN_CTRL 8'h1C
`define OFS_ADDR_UPPER 8'h20
`define OFS_ADDR_LOWER 8'h24
`define OFS_BYTE_COUNT 8'h28
`define IC_EN_SILO 0
`define IC_EN_PRN 1
`define IC_EN_MODEM 2
`define IC_EN_NXM 3
`define IC_IND_LO 8
`define IND_W 6
`define IND_ALARM 0
`define IND_AGE 1
`define IND_PRN 2
`define IND_MODEM 3
`define IND_RING 4
`define IND_NXM 5
`define WIN_VALID_BIT 15
`define PC_GO 0
`define PC_NXM 4
`define SP_AGE_LO 16
`define ALARM_MAX 9'h100
`define NUM_LINES 16
`define CLK_NS 20
`define TICK_NS 1000000
`define STROBE_NS 1000
`endif

// ==== verilog/silo_pkg.sv ====
// Types shared by the receive silo block
package silo_pkg;
  typedef enum logic [2:0] {
    PIDLE = 3'b001,
    PFETCH = 3'b010,
    PSTROBE = 3'b100
  } prn_state_e;

  typedef struct packed {
    logic [3:0] line;
    logic [7:0] ch;
  } silo_entry_s;

  typedef struct packed {
    logic [15:0] carrier;
    logic [15:0] ring;
  } modem_pins_s;

  typedef struct packed {
    logic [3:0] intEn;
    logic [5:0] intInd;
    logic [15:0] lineEn;
    logic [15:0] carrierOut;
    logic [15:0] carChg;
    logic [15:0] ringChg;
    logic [8:0] alarmLvl;
    logic [15:0] ageLimit;
    logic [15:0] ageCnt;
    logic ageFired;
    logic [23:0] tickCnt;
    logic go;
    logic nxmErr;
    logic [15:0] addrUp;
    logic [15:0] addrLo;
    logic [15:0] byteCnt;
    prn_state_e prnState;
    logic [7:0] strobeCnt;
    modem_pins_s modemMeta;
    modem_pins_s modemSync;
    modem_pins_s modemPrev;
    logic [2:0] prnMeta;
    logic [2:0] prnSync;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic memReq;
    logic [31:0] memAddr;
    logic [7:0] prnData;
    logic prnStrobe;
  } core_state_s;
endpackage

// ==== verilog/silo_fifo.sv ====
// Shared receive silo storage, first in first out
`timescale 1ns/10ps
module silo_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2048,
  parameter int CNT_W = $clog2(DEPTH) + 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  input wire logic pop,
  output logic [WIDTH-1:0] popData,
  output logic [CNT_W-1:0] count,
  output logic empty,
  output logic full
);
  localparam int PTR_W = $clog2(DEPTH);
  typedef struct packed {
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [CNT_W-1:0] count;
  } fifo_state_s;

  fifo_state_s s_reg;
  fifo_state_s s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic wrEn;
  logic rdEn;

  // Full silo drops the newcomer, stored entries stay intact
  assign wrEn = push && !full;
  assign rdEn = pop && !empty;
  assign empty = (s_reg.count == '0);
  assign full = (s_reg.count == CNT_W'(DEPTH));
  assign count = s_reg.count;
  assign popData = mem[s_reg.rdPtr];

  // Pointer and fill bookkeeping
  always_comb begin
    s_next = s_reg;
    if (wrEn) begin
      s_next.wrPtr = s_reg.wrPtr + PTR_W'(1);
    end
    if (rdEn) begin
      s_next.rdPtr = s_reg.rdPtr + PTR_W'(1);
    end
    if (wrEn && !rdEn) begin
      s_next.count = s_reg.count + CNT_W'(1);
    end else if (rdEn && !wrEn) begin
      s_next.count = s_reg.count - CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Entry storage, line number kept with each character
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[s_reg.wrPtr] <= pushData;
    end
  end
endmodule

// ==== verilog/serial_receive_silo_printer_modem.sv ====
// Receive silo, printer transfer and modem control behind an APB slave
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
`include "silo_regs.svh"
module serial_receive_silo_printer_modem import silo_pkg::*; #(
  parameter int SILO_DEPTH = 2048,
  parameter int unsigned AGE_TICK_CYCLES = `TICK_NS / `CLK_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxValid,
  input wire silo_entry_s rxEntry,
  input wire modem_pins_s modemIn,
  output logic [15:0] carrierOut,
  input wire logic [2:0] prnStatusIn,
  output logic [7:0] prnData,
  output logic prnStrobe,
  output logic memReq,
  output logic [31:0] memAddr,
  input wire logic memAck,
  input wire logic memErr,
  input wire logic [7:0] memData,
  output logic irq
);
  localparam int CNT_W = $clog2(SILO_DEPTH) + 1;
  localparam int STROBE_CYC = (`STROBE_NS + `CLK_NS - 1) / `CLK_NS;

  core_state_s s_reg;
  core_state_s s_next;
  silo_entry_s siloHead;
  logic [CNT_W-1:0] siloCount;
  logic siloEmpty;
  logic siloFull;
  logic siloPush;
  logic siloPop;
  logic apbAccess;
  logic ageTick;
  logic [15:0] carDelta;
  logic [15:0] ringRise;

  // Silo storage
  silo_fifo #(
    .WIDTH($bits(silo_entry_s)),
    .DEPTH(SILO_DEPTH),
    .CNT_W(CNT_W)
  ) u_silo (
    .clk(clk),
    .rst_n(rst_n),
    .push(siloPush),
    .pushData(rxEntry),
    .pop(siloPop),
    .popData(siloHead),
    .count(siloCount),
    .empty(siloEmpty),
    .full(siloFull)
  );

  // Outputs straight from the state register
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign carrierOut = s_reg.carrierOut;
  assign prnData = s_reg.prnData;
  assign prnStrobe = s_reg.prnStrobe;
  assign memReq = s_reg.memReq;
  assign memAddr = s_reg.memAddr;
  assign irq = s_reg.irq;

  // Event terms
  assign siloPush = rxValid && s_reg.lineEn[rxEntry.line];
  assign apbAccess = psel && penable && !s_reg.pready;
  assign siloPop = apbAccess && !pwrite && (paddr == `OFS_SILO_WIN);
  assign ageTick = (s_reg.tickCnt == 24'(AGE_TICK_CYCLES - 1));
  assign carDelta = s_reg.modemSync.carrier ^ s_reg.modemPrev.carrier;
  assign ringRise = s_reg.modemSync.ring & ~s_reg.modemPrev.ring;

  // Next state of the whole block
  always_comb begin
    s_next = s_reg;
    s_next.modemMeta = modemIn;
    s_next.modemSync = s_reg.modemMeta;
    s_next.modemPrev = s_reg.modemSync;
    s_next.prnMeta = prnStatusIn;
    s_next.prnSync = s_reg.prnMeta;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.tickCnt = ageTick ? '0 : s_reg.tickCnt + 24'h1;

    // Printer transfer engine
    case (s_reg.prnState)
      PIDLE: begin
        if (s_reg.go) begin
          if (s_reg.byteCnt == '0) begin
            s_next.go = 1'b0;
            if (s_reg.intEn[`IC_EN_PRN]) begin
              s_next.intInd[`IND_PRN] = 1'b1;
            end
          end else if (!s_reg.prnSync[0]) begin
            s_next.memReq = 1'b1;
            s_next.memAddr = {s_reg.addrUp, s_reg.addrLo};
            s_next.prnState = PFETCH;
          end
        end
      end
      PFETCH: begin
        if (memErr) begin
          s_next.memReq = 1'b0;
          s_next.go = 1'b0;
          s_next.nxmErr = 1'b1;
          if (s_reg.intEn[`IC_EN_NXM]) begin
            s_next.intInd[`IND_NXM] = 1'b1;
          end
          s_next.prnState = PIDLE;
        end else if (memAck) begin
          s_next.memReq = 1'b0;
          s_next.prnData = memData;
          s_next.prnStrobe = 1'b1;
          s_next.strobeCnt = 8'(STROBE_CYC - 1);
          {s_next.addrUp, s_next.addrLo} = {s_reg.addrUp, s_reg.addrLo} + 32'h1;
          s_next.byteCnt = s_reg.byteCnt - 16'h1;
          s_next.prnState = PSTROBE;
        end
      end
      PSTROBE: begin
        if (s_reg.strobeCnt == '0) begin
          s_next.prnStrobe = 1'b0;
          s_next.prnState = PIDLE;
        end else begin
          s_next.strobeCnt = s_reg.strobeCnt - 8'h1;
        end
      end
      default: begin
        s_next.prnState = PIDLE;
      end
    endcase

    // APB slave, one wait cycle then pready
    if (apbAccess) begin
      s_next.pready = 1'b1;
      s_next.prdata = '0;
      case (paddr)
        `OFS_INT_CTRL: begin
          s_next.prdata = {18'h0, s_reg.intInd, 4'h0, s_reg.intEn};
          if (pwrite) begin
            s_next.intEn = pwdata[3:0];
            s_next.intInd = (s_reg.intInd & ~pwdata[`IC_IND_LO +: `IND_W])
              | (s_next.intInd & ~s_reg.intInd); // Fresh sets survive the clear
          end
        end
        `OFS_LINE_EN: begin
          s_next.prdata = {16'h0, s_reg.lineEn};
          if (pwrite) begin
            s_next.lineEn = pwdata[15:0];
          end
        end
        `OFS_SILO_WIN: begin
          if (!siloEmpty) begin
            s_next.prdata = {16'h0, 1'b1, 3'h0, siloHead};
          end
        end
        `OFS_CAR_ASSERT: begin
          s_next.prdata = {16'h0, s_reg.carrierOut};
          if (pwrite) begin
            s_next.carrierOut = pwdata[15:0];
          end
        end
        `OFS_CAR_DETECT: begin
          s_next.prdata = {s_reg.carChg, s_reg.modemSync.carrier};
          if (!pwrite) begin
            s_next.carChg = '0;
          end
        end
        `OFS_RING_DETECT: begin
          s_next.prdata = {s_reg.ringChg, s_reg.modemSync.ring};
          if (!pwrite) begin
            s_next.ringChg = '0;
          end
        end
        `OFS_SILO_PARAM: begin
          s_next.prdata = {s_reg.ageLimit, 7'h0, s_reg.alarmLvl};
          if (pwrite) begin
            s_next.ageLimit = pwdata[`SP_AGE_LO +: 16];
            s_next.alarmLvl = (pwdata[8:0] > `ALARM_MAX) ? `ALARM_MAX : pwdata[8:0];
          end
        end
        `OFS_PRN_CTRL: begin
          s_next.prdata = {27'h0, s_reg.nxmErr, s_reg.prnSync, s_reg.go};
          if (pwrite) begin
            if (pwdata[`PC_GO]) begin
              s_next.go = 1'b1;
            end
            if (pwdata[`PC_NXM] && !(s_reg.prnState == PFETCH && memErr)) begin
              s_next.nxmErr = 1'b0;
            end
          end
        end
        `OFS_ADDR_UPPER: begin
          s_next.prdata = {16'h0, s_reg.addrUp};
          if (pwrite) begin
            s_next.addrUp = pwdata[15:0];
          end
        end
        `OFS_ADDR_LOWER: begin
          s_next.prdata = {16'h0, s_reg.addrLo};
          if (pwrite) begin
            s_next.addrLo = pwdata[15:0];
          end
        end
        `OFS_BYTE_COUNT: begin
          s_next.prdata = {16'h0, s_reg.byteCnt};
          if (pwrite) begin
            s_next.byteCnt = pwdata[15:0];
          end
        end
        default: begin
          s_next.pslverr = 1'b1;
        end
      endcase
    end

    // Modem change capture, set wins over read clear
    s_next.carChg = s_next.carChg | carDelta;
    s_next.ringChg = s_next.ringChg | (s_reg.modemSync.ring ^ s_reg.modemPrev.ring);
    if (s_reg.intEn[`IC_EN_MODEM] && (|carDelta || |(s_reg.modemSync.ring
        ^ s_reg.modemPrev.ring))) begin
      s_next.intInd[`IND_MODEM] = 1'b1;
    end
    if (s_reg.intEn[`IC_EN_MODEM] && |ringRise) begin
      s_next.intInd[`IND_RING] = 1'b1;
    end

    // Silo alarm level and age timer
    if (s_reg.intEn[`IC_EN_SILO] && s_reg.alarmLvl != '0
        && 32'(siloCount) >= 32'(s_reg.alarmLvl)) begin
      s_next.intInd[`IND_ALARM] = 1'b1;
    end
    if (siloEmpty) begin
      s_next.ageCnt = '0;
      s_next.ageFired = 1'b0;
    end else begin
      if (ageTick && s_reg.ageCnt != 16'hFFFF) begin
        s_next.ageCnt = s_reg.ageCnt + 16'h1;
      end
      if (!s_reg.ageFired && s_reg.ageLimit != '0 && s_reg.ageCnt >= s_reg.ageLimit) begin
        s_next.ageFired = 1'b1;
        if (s_reg.intEn[`IC_EN_SILO]) begin
          s_next.intInd[`IND_AGE] = 1'b1;
        end
      end
    end

    // Printer status faults never reach the interrupt line
    s_next.irq = |s_next.intInd;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.prnState <= PIDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Checks on the block's own behaviour
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_drop_disabled: assert property (rxValid && !s_reg.lineEn[rxEntry.line] && !siloPop
    |=> siloCount == $past(siloCount))
    else $error("character from disabled line stored");
  a_empty_window: assert property (siloPop && siloEmpty |=> prdata == 32'h0 && pready)
    else $error("empty window frame not zero");
  a_pop_advance: assert property (siloPop && !siloEmpty && !siloPush
    |=> siloCount == $past(siloCount) - CNT_W'(1))
    else $error("window read did not pop");
  a_full_drop: assert property (siloFull && !siloPop |=> siloCount == $past(siloCount))
    else $error("full silo grew");
  a_alarm_set: assert property (s_reg.intEn[`IC_EN_SILO] && s_reg.alarmLvl != '0
    && 32'(siloCount) >= 32'(s_reg.alarmLvl) |=> s_reg.intInd[`IND_ALARM] && irq)
    else $error("alarm level missed");
  a_alarm_cap: assert property (s_reg.alarmLvl <= `ALARM_MAX)
    else $error("alarm level above cap");
  a_go_done: assert property (s_reg.prnState == PIDLE && s_reg.go && s_reg.byteCnt == '0
    && !(apbAccess && pwrite) |=> !s_reg.go)
    else $error("go not cleared at end");
  a_byte_step: assert property (s_reg.prnState == PFETCH && memAck && !memErr
    && !(apbAccess && pwrite) |=> s_reg.byteCnt == $past(s_reg.byteCnt) - 16'h1 && prnStrobe)
    else $error("count not stepped");
  a_nxm_halt: assert property (s_reg.prnState == PFETCH && memErr
    && !(apbAccess && pwrite) |=> !s_reg.go && s_reg.nxmErr && !memReq)
    else $error("bus error did not halt");
  a_carrier_drive: assert property (apbAccess && pwrite && paddr == `OFS_CAR_ASSERT
    |=> carrierOut == $past(pwdata[15:0]))
    else $error("carrier output not driven");
  a_ring_irq: assert property (s_reg.intEn[`IC_EN_MODEM] && |ringRise
    |=> s_reg.intInd[`IND_RING] && irq)
    else $error("ring interrupt missed");

  c_valid_read: cover property (siloPop && !siloEmpty);
  c_age_fire: cover property (s_reg.intInd[`IND_AGE]);
  c_print_done: cover property (s_reg.go ##1 !s_reg.go && s_reg.intInd[`IND_PRN]);
  c_ring_seen: cover property (s_reg.intInd[`IND_RING]);
endmodule

// ==== verif/mem_model.sv ====
// Memory model answering the printer fetch requests
`timescale 1ns/10ps
module mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic memReq,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] failAddr,
  output logic memAck,
  output logic memErr,
  output logic [7:0] memData
);
  int waitCnt;

  // Answers after a random stall; data churns outside the answer cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memAck <= 1'b0;
      memErr <= 1'b0;
      memData <= 8'h00;
      waitCnt <= 0;
    end else if (memAck || memErr || !memReq) begin
      memAck <= 1'b0;
      memErr <= 1'b0;
      memData <= ~memData;
    end else if (waitCnt > 0) begin
      waitCnt <= waitCnt - 1;
      memData <= ~memData;
    end else begin
      memAck <= (memAddr !== failAddr);
      memErr <= (memAddr === failAddr); // Bus error on the chosen address
      memData <= memAddr[7:0] ^ 8'h5A;
      waitCnt <= $urandom_range(3, 0);
    end
  end
endmodule

// ==== verif/serial_receive_silo_printer_modem_bench.sv ====
// Self-checking bench for the receive silo, printer and modem block
`timescale 1ns/10ps
`include "silo_regs.svh"
module serial_receive_silo_printer_modem_bench import silo_pkg::*;;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rxValid, irq;
  logic prnStrobe, memReq, memAck, memErr, lastStrobe;
  logic [7:0] paddr, prnData, memData;
  logic [31:0] pwdata, prdata, memAddr, failAddr;
  logic [15:0] carrierOut;
  logic [2:0] prnStatusIn;
  silo_entry_s rxEntry;
  modem_pins_s modemIn;
  logic [32:0] expQ[$];
  logic [7:0] prnQ[$];
  logic [31:0] frames[$];
  int miscompares, samplesChecked;

  serial_receive_silo_printer_modem #(.SILO_DEPTH(16), .AGE_TICK_CYCLES(4)) dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxValid(rxValid), .rxEntry(rxEntry), .modemIn(modemIn),
    .carrierOut(carrierOut), .prnStatusIn(prnStatusIn), .prnData(prnData),
    .prnStrobe(prnStrobe), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
    .memErr(memErr), .memData(memData), .irq(irq)
  );

  mem_model mem (
    .clk(clk), .rst_n(rst_n), .memReq(memReq), .memAddr(memAddr),
    .failAddr(failAddr), .memAck(memAck), .memErr(memErr), .memData(memData)
  );

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic cmp_word(input string nm, input logic [32:0] e, input logic [32:0] g);
    samplesChecked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    samplesChecked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back({1'b0, e});
    apb(1'b0, a, 32'h0);
  endtask

  // One character on a line; noted as a frame if it must be stored
  task automatic rxf(input logic [3:0] l, input logic [7:0] c, input logic keep);
    @(posedge clk);
    rxValid <= 1'b1;
    rxEntry <= '{line: l, ch: c};
    @(posedge clk);
    rxValid <= 1'b0;
    if (keep) frames.push_back({16'h0, 1'b1, 3'h0, l, c});
  endtask

  task automatic drain();
    while (frames.size() > 0) rd(`OFS_SILO_WIN, frames.pop_front());
    rd(`OFS_SILO_WIN, 32'h0);
  endtask

  task automatic waitIrq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (irq !== 1'b1) miscompares++;
  endtask

  // Monitor: read answers and printer bytes against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      cmp_word("prdata", expQ.pop_front(), {pslverr, prdata});
    end
    if (prnStrobe && !lastStrobe) cmp_byte("prnData", prnQ.pop_front(), prnData);
    lastStrobe = prnStrobe;
  end

  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  // Main sequence
  initial begin
    logic [31:0] m;
    {psel, penable, pwrite, rxValid, rst_n, lastStrobe} = 6'h00;
    {paddr, pwdata, failAddr} = '0;
    rxEntry = '0;
    modemIn = '0;
    prnStatusIn = 3'h0;
    void'($urandom(23575));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(`OFS_INT_CTRL, 32'h0);
    expQ.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h2C, 32'h0);
    // Masked lines and masked silo interrupt
    m = $urandom() | 32'h1;
    wr(`OFS_LINE_EN, m);
    wr(`OFS_SILO_PARAM, 32'h1);
    for (int i = 0; i < 10; i++) begin
      logic [3:0] l;
      l = 4'($urandom_range(15, 0));
      rxf(l, 8'($urandom()), m[l]);
    end
    drain();
    rd(`OFS_INT_CTRL, 32'h0);
    // Overfull silo keeps the oldest entries
    wr(`OFS_LINE_EN, 32'hFFFF);
    wr(`OFS_SILO_PARAM, 32'h0);
    for (int i = 0; i < 20; i++) rxf(4'(i), 8'(i + 64), i < 16);
    drain();
    // Alarm level boundary and clamp
    wr(`OFS_SILO_PARAM, 32'hFFFF_01FF);
    rd(`OFS_SILO_PARAM, 32'hFFFF_0100);
    wr(`OFS_SILO_PARAM, 32'h3);
    wr(`OFS_INT_CTRL, 32'h1);
    rxf(4'h2, 8'h11, 1'b1);
    rxf(4'h5, 8'h22, 1'b1);
    repeat (4) @(posedge clk);
    rd(`OFS_INT_CTRL, 32'h1);
    rxf(4'h9, 8'h33, 1'b1);
    repeat (4) @(posedge clk);
    cmp_word("irq", 33'h1, {32'h0, irq});
    rd(`OFS_INT_CTRL, 32'h101);
    drain();
    wr(`OFS_INT_CTRL, 32'h3F01);
    rd(`OFS_INT_CTRL, 32'h1);
    // Age interval
    wr(`OFS_SILO_PARAM, 32'h0002_0000);
    rxf(4'hF, 8'hC3, 1'b1);
    repeat (40) @(posedge clk);
    rd(`OFS_INT_CTRL, 32'h201);
    drain();
    // Printer transfer to completion
    wr(`OFS_INT_CTRL, 32'h3F0A);
    wr(`OFS_ADDR_UPPER, 32'h0);
    wr(`OFS_ADDR_LOWER, 32'h100);
    wr(`OFS_BYTE_COUNT, 32'h3);
    for (int i = 0; i < 3; i++) prnQ.push_back(8'(i) ^ 8'h5A);
    wr(`OFS_PRN_CTRL, 32'h1);
    waitIrq();
    rd(`OFS_INT_CTRL, 32'h40A);
    rd(`OFS_ADDR_LOWER, 32'h103);
    rd(`OFS_BYTE_COUNT, 32'h0);
    rd(`OFS_PRN_CTRL, 32'h0);
    cmp_word("bytes left", 33'h0, 33'(prnQ.size()));
    wr(`OFS_INT_CTRL, 32'h3F0A);
    // Bus error on the second byte
    failAddr <= 32'h201;
    wr(`OFS_ADDR_LOWER, 32'h200);
    wr(`OFS_BYTE_COUNT, 32'h3);
    prnQ.push_back(8'h5A);
    wr(`OFS_PRN_CTRL, 32'h1);
    waitIrq();
    rd(`OFS_INT_CTRL, 32'h200A);
    rd(`OFS_PRN_CTRL, 32'h10);
    rd(`OFS_ADDR_LOWER, 32'h201);
    rd(`OFS_BYTE_COUNT, 32'h2);
    wr(`OFS_PRN_CTRL, 32'h10);
    wr(`OFS_INT_CTRL, 32'h3F0A);
    // Printer fault pin shows but never interrupts
    prnStatusIn <= 3'b111;
    repeat (4) @(posedge clk);
    rd(`OFS_PRN_CTRL, 32'hE);
    cmp_word("irq", 33'h0, {32'h0, irq});
    prnStatusIn <= 3'b000;
    // Modem: carrier drive, ring, answer
    m = $urandom();
    wr(`OFS_CAR_ASSERT, m);
    repeat (2) @(posedge clk);
    cmp_word("carrierOut", {17'h0, m[15:0]}, {17'h0, carrierOut});
    wr(`OFS_INT_CTRL, 32'h3F04);
    modemIn <= '{carrier: 16'h0, ring: 16'h0008};
    repeat (6) @(posedge clk);
    cmp_word("irq", 33'h1, {32'h0, irq});
    rd(`OFS_INT_CTRL, 32'h1804);
    rd(`OFS_RING_DETECT, 32'h0008_0008);
    rd(`OFS_RING_DETECT, 32'h8);
    wr(`OFS_INT_CTRL, 32'h3F04);
    wr(`OFS_CAR_ASSERT, 32'h8);
    modemIn <= '{carrier: 16'h0008, ring: 16'h0008};
    repeat (6) @(posedge clk);
    rd(`OFS_INT_CTRL, 32'h0804);
    rd(`OFS_CAR_DETECT, 32'h0008_0008);
    rd(`OFS_CAR_DETECT, 32'h8);
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule
